// *** dv/ccr_regs_test.sv ***
// Self-checking testbench of the comparator register bank.
module ccr_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ccr_pkg::*;

  // ----------------------------------------------------------------------
  // Compare macro, counters and stimulus signals.
  // ----------------------------------------------------------------------
  `define CHK(got, exp) begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("[ERR] %0t got %h expected %h", $time, got, exp); \
    end \
  end

  int          err_total;
  int          n_compared;
  logic        clk;
  logic        rst;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic        cmpa_raw;
  logic        cmpb_raw;
  logic        a_en, b_en, a_rng, b_rng;
  logic [1:0]  a_pos, a_neg, b_pos, b_neg, icap, ecap;
  logic [7:0]  opts;
  logic        a_lut, b_lut, a_flag, b_flag;
  logic [7:0]  v;
  logic [7:0]  pat;
  logic [3:0]  code;

  ccr_regs ccr_regs_inst (
    .clk                       (clk),
    .rst                       (rst),
    .addr                      (addr),
    .wdata                     (wdata),
    .wr                        (wr),
    .rd                        (rd),
    .rdata                     (rdata),
    .cmpa_raw                  (cmpa_raw),
    .cmpb_raw                  (cmpb_raw),
    .cmpa_power_enable         (a_en),
    .cmpb_power_enable         (b_en),
    .cmpa_range_limit          (a_rng),
    .cmpb_range_limit          (b_rng),
    .cmpa_pos_input_sel        (a_pos),
    .cmpa_neg_input_sel        (a_neg),
    .cmpb_pos_input_sel        (b_pos),
    .cmpb_neg_input_sel        (b_neg),
    .internal_cap_select       (icap),
    .external_cap_pin_select   (ecap),
    .comparator_output_options (opts),
    .cmpa_lut_out              (a_lut),
    .cmpb_lut_out              (b_lut),
    .cmpa_latched_flag         (a_flag),
    .cmpb_latched_flag         (b_flag)
  );

  // ----------------------------------------------------------------------
  // Clock, bus tasks and closing task.
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Entered just after a rising edge; leaves one idle edge so that the
  // strobe is never assigned twice in one time step.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe, then return to 0.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk);
    #1;
    `CHK(rdata, 8'h00)
    @(posedge clk);
  endtask

  task automatic end_sim();
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Test sequence.
  // ----------------------------------------------------------------------
  initial begin
    err_total = 0;
    n_compared = 0;
    rst <= 1'b1;
    addr <= 8'h00;
    wdata <= 8'h00;
    wr <= 1'b0;
    rd <= 1'b0;
    cmpa_raw <= 1'b0;
    cmpb_raw <= 1'b0;
    cyc(6);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values, unmapped reads.
    `CHK({a_en, b_en, a_rng, b_rng, a_pos, b_neg}, 8'h00)
    rd_reg(CCR_ADDR_SEL, v); `CHK(v, 8'h00)
    rd_reg(CCR_ADDR_CAP, v); `CHK(v, 8'h00)
    rd_reg(CCR_ADDR_ENR, v); `CHK(v, 8'h00)
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h00)
    rd_reg(8'h62, v); `CHK(v, 8'h00)
    // Every code of every input selector field.
    for (int i = 0; i < 6; i++) begin
      pat = (i < 4) ? 8'h55 * i[7:0] : ((i == 4) ? 8'he4 : 8'h1b);
      wr_reg(CCR_ADDR_SEL, pat);
      `CHK(b_pos, pat[7:6])
      `CHK(b_neg, pat[5:4])
      `CHK(a_pos, pat[3:2])
      `CHK(a_neg, pat[1:0])
      rd_reg(CCR_ADDR_SEL, v); `CHK(v, pat)
    end
    // Capacitor fields; upper bits stay zero.
    for (int i = 0; i < 4; i++) begin
      pat = 8'hf0 | (8'h05 * i[7:0]);
      wr_reg(CCR_ADDR_CAP, pat);
      `CHK(icap, pat[3:2])
      `CHK(ecap, pat[1:0])
      rd_reg(CCR_ADDR_CAP, v); `CHK(v, pat & 8'h0f)
    end
    // Enable and range bits, one at a time then all.
    for (int i = 0; i < 5; i++) begin
      pat = (i < 4) ? (8'hcc | (8'h01 << (i + (i / 2) * 2))) : 8'hff;
      wr_reg(CCR_ADDR_ENR, pat);
      `CHK(a_en, pat[0])
      `CHK(a_rng, pat[1])
      `CHK(b_en, pat[4])
      `CHK(b_rng, pat[5])
      rd_reg(CCR_ADDR_ENR, v); `CHK(v, pat & 8'h33)
    end
    wr_reg(CCR_ADDR_OPT, 8'ha5);
    `CHK(opts, 8'ha5)
    wr_reg(8'h62, 8'hff);
    rd_reg(8'h62, v); `CHK(v, 8'h00)
    rd_reg(CCR_ADDR_ENR, v); `CHK(v, 8'h33)
    // Live states gated by enable.
    wr_reg(CCR_ADDR_OPT, 8'h00);
    wr_reg(CCR_ADDR_ENR, 8'h00);
    cmpa_raw <= 1'b1;
    cmpb_raw <= 1'b1;
    cyc(5);
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h00)
    wr_reg(CCR_ADDR_ENR, 8'h11);
    cyc(4);
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h33)
    cmpa_raw <= 1'b0;
    cyc(5);
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h23)
    wr_reg(CCR_ADDR_RDC, 8'hff);
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h23)
    wr_reg(CCR_ADDR_RDC, 8'h02);
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h22)
    cmpb_raw <= 1'b0;
    cyc(5);
    wr_reg(CCR_ADDR_RDC, 8'h00);
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h00)
    // Clear sources: A by edge of B function, B by software zero.
    wr_reg(CCR_ADDR_OPT, 8'h02);
    cmpa_raw <= 1'b1;
    cmpb_raw <= 1'b1;
    cyc(5);
    cmpa_raw <= 1'b0;
    cmpb_raw <= 1'b0;
    cyc(5);
    wr_reg(CCR_ADDR_RDC, 8'h00);
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h01)
    `CHK({b_flag, a_flag}, 2'b01)
    cmpb_raw <= 1'b1;
    cyc(5);
    cmpb_raw <= 1'b0;
    cyc(5);
    wr_reg(CCR_ADDR_LUT, 8'h0f);
    cyc(4);
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h03)
    wr_reg(CCR_ADDR_LUT, 8'hff);
    cyc(4);
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h02)
    wr_reg(CCR_ADDR_RDC, 8'h00);
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h00)
    // Clear sources swapped: B by edge of A function, A by software zero.
    wr_reg(CCR_ADDR_LUT, 8'h00);
    wr_reg(CCR_ADDR_OPT, 8'h20);
    cmpb_raw <= 1'b1;
    cyc(5);
    cmpb_raw <= 1'b0;
    cyc(5);
    wr_reg(CCR_ADDR_RDC, 8'h00);
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h02)
    wr_reg(CCR_ADDR_LUT, 8'h0f);
    cyc(4);
    rd_reg(CCR_ADDR_RDC, v); `CHK(v, 8'h00)
    // All sixteen functions over all input pairs.
    for (int i = 0; i < 4; i++) begin
      cmpa_raw <= i[0];
      cmpb_raw <= i[1];
      cyc(5);
      for (int c = 0; c < 16; c++) begin
        code = c[3:0];
        wr_reg(CCR_ADDR_LUT, {code, code});
        cyc(2);
        #1;
        `CHK(a_lut, code[{~i[0], ~i[1]}])
        `CHK(b_lut, code[{~i[1], ~i[0]}])
        @(posedge clk);
      end
    end
    // Named functions with own and other inputs apart: A high, B low.
    cmpa_raw <= 1'b1;
    cmpb_raw <= 1'b0;
    cyc(5);
    wr_reg(CCR_ADDR_LUT, 8'h71);
    cyc(2);
    `CHK({b_lut, a_lut}, 2'b10)
    wr_reg(CCR_ADDR_LUT, 8'ha3);
    cyc(2);
    `CHK({b_lut, a_lut}, 2'b01)
    // Second reset in mid-run.
    rst <= 1'b1;
    cyc(2);
    rst <= 1'b0;
    @(posedge clk);
    rd_reg(CCR_ADDR_SEL, v); `CHK(v, 8'h00)
    `CHK({a_en, b_en, icap, ecap, opts}, 14'h0000)
    end_sim();
  end

endmodule

// *** hdl/ccr_cmp_core.sv ***
// Logic-function outputs and latched flags of both comparators.
module ccr_cmp_core (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Register bank side
  ccr_cmp_if.core   cif
);
  import ccr_pkg::*;

  logic lut_a_q, lut_a_d, lut_b_q, lut_b_d;
  logic prev_a_q, prev_b_q;
  logic flag_a_q, flag_a_d, flag_b_q, flag_b_d;
  logic rise_a, rise_b, clr_a, clr_b;

  // ----------------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------------
  always_comb begin
    lut_a_d = ccr_lut(cif.cmpa_func_sel, cif.cmpa_live, cif.cmpb_live);
    lut_b_d = ccr_lut(cif.cmpb_func_sel, cif.cmpb_live, cif.cmpa_live);
    rise_a  = lut_a_q & ~prev_a_q;
    rise_b  = lut_b_q & ~prev_b_q;
    clr_a   = cif.cmpa_clr_src ? rise_b : cif.cmpa_sw_clr;
    clr_b   = cif.cmpb_clr_src ? rise_a : cif.cmpb_sw_clr;
    // A high comparator sets its flag even in a clearing cycle.
    flag_a_d = flag_a_q;
    if (cif.cmpa_live) begin
      flag_a_d = 1'b1;
    end else if (clr_a) begin
      flag_a_d = 1'b0;
    end
    flag_b_d = flag_b_q;
    if (cif.cmpb_live) begin
      flag_b_d = 1'b1;
    end else if (clr_b) begin
      flag_b_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      lut_a_q  <= 1'b0;
      lut_b_q  <= 1'b0;
      prev_a_q <= 1'b0;
      prev_b_q <= 1'b0;
      flag_a_q <= 1'b0;
      flag_b_q <= 1'b0;
    end else begin
      lut_a_q  <= lut_a_d;
      lut_b_q  <= lut_b_d;
      prev_a_q <= lut_a_q;
      prev_b_q <= lut_b_q;
      flag_a_q <= flag_a_d;
      flag_b_q <= flag_b_d;
    end
  end

  assign cif.cmpa_lut  = lut_a_q;
  assign cif.cmpb_lut  = lut_b_q;
  assign cif.cmpa_flag = flag_a_q;
  assign cif.cmpb_flag = flag_b_q;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_lut_func;
    1'b1 |=> lut_a_q == ccr_lut($past(cif.cmpa_func_sel),
                                $past(cif.cmpa_live), $past(cif.cmpb_live))
      && lut_b_q == ccr_lut($past(cif.cmpb_func_sel),
                            $past(cif.cmpb_live), $past(cif.cmpa_live));
  endproperty
  a_lut_func: assert property (p_lut_func)
    else $error("logic function output wrong");

  property p_edge_clear_a;
    cif.cmpa_clr_src && rise_b && !cif.cmpa_live |=> !flag_a_q;
  endproperty
  a_edge_clear_a: assert property (p_edge_clear_a)
    else $error("cmpa flag not cleared by cmpb function edge");

  property p_sw_ignored_b;
    cif.cmpb_clr_src && cif.cmpb_sw_clr && !rise_a && flag_b_q
      |=> flag_b_q;
  endproperty
  a_sw_ignored_b: assert property (p_sw_ignored_b)
    else $error("cmpb flag cleared by software in edge mode");

  property p_sw_clear_b;
    !cif.cmpb_clr_src && cif.cmpb_sw_clr && !cif.cmpb_live |=> !flag_b_q;
  endproperty
  a_sw_clear_b: assert property (p_sw_clear_b)
    else $error("cmpb flag not cleared by software write");

  c_edge_clear: cover property (cif.cmpa_clr_src && rise_b && flag_a_q);
endmodule

// *** hdl/ccr_cmp_if.sv ***
// Signals passed between the register bank and the comparator output logic.
interface ccr_cmp_if;
  logic       cmpa_live;
  logic       cmpb_live;
  logic [3:0] cmpa_func_sel;
  logic [3:0] cmpb_func_sel;
  logic       cmpa_clr_src;
  logic       cmpb_clr_src;
  logic       cmpa_sw_clr;
  logic       cmpb_sw_clr;
  logic       cmpa_lut;
  logic       cmpb_lut;
  logic       cmpa_flag;
  logic       cmpb_flag;

  modport regs (
    output cmpa_live, cmpb_live, cmpa_func_sel, cmpb_func_sel,
    output cmpa_clr_src, cmpb_clr_src, cmpa_sw_clr, cmpb_sw_clr,
    input  cmpa_lut, cmpb_lut, cmpa_flag, cmpb_flag
  );
  modport core (
    input  cmpa_live, cmpb_live, cmpa_func_sel, cmpb_func_sel,
    input  cmpa_clr_src, cmpb_clr_src, cmpa_sw_clr, cmpb_sw_clr,
    output cmpa_lut, cmpb_lut, cmpa_flag, cmpb_flag
  );
endinterface

// *** hdl/ccr_pkg.sv ***
// Shared constants and the logic-function helper of the comparator register bank.
package ccr_pkg;

  // ----------------------------------------------------------------------
  // Bus widths and register offsets.
  // ----------------------------------------------------------------------
  localparam int unsigned CCR_AW = 8;
  localparam int unsigned CCR_DW = 8;

  localparam logic [7:0] CCR_ADDR_CAP = 8'h61;
  localparam logic [7:0] CCR_ADDR_RDC = 8'h78;
  localparam logic [7:0] CCR_ADDR_SEL = 8'h79;
  localparam logic [7:0] CCR_ADDR_ENR = 8'h7a;
  localparam logic [7:0] CCR_ADDR_OPT = 8'h7b;
  localparam logic [7:0] CCR_ADDR_LUT = 8'h7c;

  // ----------------------------------------------------------------------
  // Reset value and writable-bit masks.
  // ----------------------------------------------------------------------
  localparam logic [7:0] CCR_RST_VAL  = 8'h00;
  localparam logic [7:0] CCR_CAP_MASK = 8'h0f;
  localparam logic [7:0] CCR_ENR_MASK = 8'h33;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int unsigned CCR_RDC_B_LIVE = 5;
  localparam int unsigned CCR_RDC_A_LIVE = 4;
  localparam int unsigned CCR_RDC_B_FLAG = 1;
  localparam int unsigned CCR_RDC_A_FLAG = 0;
  localparam int unsigned CCR_ENR_B_RNG  = 5;
  localparam int unsigned CCR_ENR_B_EN   = 4;
  localparam int unsigned CCR_ENR_A_RNG  = 1;
  localparam int unsigned CCR_ENR_A_EN   = 0;
  localparam int unsigned CCR_SEL_B_POS  = 6;
  localparam int unsigned CCR_SEL_B_NEG  = 4;
  localparam int unsigned CCR_SEL_A_POS  = 2;
  localparam int unsigned CCR_SEL_A_NEG  = 0;
  localparam int unsigned CCR_CAP_INT    = 2;
  localparam int unsigned CCR_CAP_EXT    = 0;
  localparam int unsigned CCR_OPT_B_CLR  = 5;
  localparam int unsigned CCR_OPT_A_CLR  = 1;
  localparam int unsigned CCR_LUT_B      = 4;
  localparam int unsigned CCR_LUT_A      = 0;

  // Code bit n is the result for own/other inputs {~a,~b} == n.
  function automatic logic ccr_lut(input logic [3:0] sel,
                                   input logic       a,
                                   input logic       b);
    return sel[{~a, ~b}];
  endfunction

endpackage

// *** hdl/ccr_regs.sv ***
// Register bank for two comparators and the analog bus capacitor setup.
//
// Chosen here: the strobed register port.
module ccr_regs (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // Register port
  input  wire logic [ccr_pkg::CCR_AW-1:0] addr,
  input  wire logic [ccr_pkg::CCR_DW-1:0] wdata,
  input  wire logic                     wr,
  input  wire logic                     rd,
  output logic      [ccr_pkg::CCR_DW-1:0] rdata,
  // Raw comparator outputs from the analog side
  input  wire logic                     cmpa_raw,
  input  wire logic                     cmpb_raw,
  // Comparator power and range
  output logic                          cmpa_power_enable,
  output logic                          cmpb_power_enable,
  output logic                          cmpa_range_limit,
  output logic                          cmpb_range_limit,
  // Comparator input selection
  output logic      [1:0]               cmpa_pos_input_sel,
  output logic      [1:0]               cmpa_neg_input_sel,
  output logic      [1:0]               cmpb_pos_input_sel,
  output logic      [1:0]               cmpb_neg_input_sel,
  // Analog bus capacitors
  output logic      [1:0]               internal_cap_select,
  output logic      [1:0]               external_cap_pin_select,
  // Output routing options and results
  output logic      [7:0]               comparator_output_options,
  output logic                          cmpa_lut_out,
  output logic                          cmpb_lut_out,
  output logic                          cmpa_latched_flag,
  output logic                          cmpb_latched_flag
);
  import ccr_pkg::*;

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  logic [7:0] cap_q, cap_d;
  logic [7:0] sel_q, sel_d;
  logic [7:0] enr_q, enr_d;
  logic [7:0] opt_q, opt_d;
  logic [7:0] func_q, func_d;
  logic [7:0] rdata_q, rdata_d;
  logic       sync_a1_q, sync_a2_q;
  logic       sync_b1_q, sync_b2_q;
  logic       live_a, live_b;
  logic       wr_rdc;

  ccr_cmp_if cif ();

  ccr_cmp_core u_core (
    .clk (clk),
    .rst (rst),
    .cif (cif)
  );

  // ----------------------------------------------------------------------
  // Comparator synchronisers.
  // ----------------------------------------------------------------------
  // The comparators switch freely, so two stages guard against metastability.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_a1_q <= 1'b0;
      sync_a2_q <= 1'b0;
      sync_b1_q <= 1'b0;
      sync_b2_q <= 1'b0;
    end else begin
      sync_a1_q <= cmpa_raw;
      sync_a2_q <= sync_a1_q;
      sync_b1_q <= cmpb_raw;
      sync_b2_q <= sync_b1_q;
    end
  end

  // A powered-down comparator may float, so its state is forced low.
  assign live_a = sync_a2_q & enr_q[CCR_ENR_A_EN];
  assign live_b = sync_b2_q & enr_q[CCR_ENR_B_EN];

  // ----------------------------------------------------------------------
  // Register writes.
  // ----------------------------------------------------------------------
  always_comb begin
    cap_d  = cap_q;
    sel_d  = sel_q;
    enr_d  = enr_q;
    opt_d  = opt_q;
    func_d = func_q;
    if (wr) begin
      if (addr == CCR_ADDR_CAP) begin
        cap_d = wdata & CCR_CAP_MASK;
      end else if (addr == CCR_ADDR_SEL) begin
        sel_d = wdata;
      end else if (addr == CCR_ADDR_ENR) begin
        enr_d = wdata & CCR_ENR_MASK;
      end else if (addr == CCR_ADDR_OPT) begin
        opt_d = wdata;
      end else if (addr == CCR_ADDR_LUT) begin
        func_d = wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cap_q  <= CCR_RST_VAL;
      sel_q  <= CCR_RST_VAL;
      enr_q  <= CCR_RST_VAL;
      opt_q  <= CCR_RST_VAL;
      func_q <= CCR_RST_VAL;
    end else begin
      cap_q  <= cap_d;
      sel_q  <= sel_d;
      enr_q  <= enr_d;
      opt_q  <= opt_d;
      func_q <= func_d;
    end
  end

  // ----------------------------------------------------------------------
  // Flag clearing and logic-function settings.
  // ----------------------------------------------------------------------
  // Writing one to a flag bit does nothing; a zero clears it only in software-clear mode (option bit 1 or 5 low).
  assign wr_rdc            = wr && (addr == CCR_ADDR_RDC);
  assign cif.cmpa_live     = live_a;
  assign cif.cmpb_live     = live_b;
  assign cif.cmpa_func_sel = func_q[CCR_LUT_A +: 4];
  assign cif.cmpb_func_sel = func_q[CCR_LUT_B +: 4];
  assign cif.cmpa_clr_src  = opt_q[CCR_OPT_A_CLR];
  assign cif.cmpb_clr_src  = opt_q[CCR_OPT_B_CLR];
  assign cif.cmpa_sw_clr   = wr_rdc && !wdata[CCR_RDC_A_FLAG];
  assign cif.cmpb_sw_clr   = wr_rdc && !wdata[CCR_RDC_B_FLAG];

  // ----------------------------------------------------------------------
  // Register reads.
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_d = 8'h00;
    if (rd) begin
      if (addr == CCR_ADDR_CAP) begin
        rdata_d = cap_q;
      end else if (addr == CCR_ADDR_RDC) begin
        rdata_d[CCR_RDC_B_LIVE] = live_b;
        rdata_d[CCR_RDC_A_LIVE] = live_a;
        rdata_d[CCR_RDC_B_FLAG] = cif.cmpb_flag;
        rdata_d[CCR_RDC_A_FLAG] = cif.cmpa_flag;
      end else if (addr == CCR_ADDR_SEL) begin
        rdata_d = sel_q;
      end else if (addr == CCR_ADDR_ENR) begin
        rdata_d = enr_q;
      end else if (addr == CCR_ADDR_OPT) begin
        rdata_d = opt_q;
      end else if (addr == CCR_ADDR_LUT) begin
        rdata_d = func_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  assign rdata                     = rdata_q;
  assign cmpa_power_enable         = enr_q[CCR_ENR_A_EN];
  assign cmpb_power_enable         = enr_q[CCR_ENR_B_EN];
  assign cmpa_range_limit          = enr_q[CCR_ENR_A_RNG];
  assign cmpb_range_limit          = enr_q[CCR_ENR_B_RNG];
  assign cmpb_pos_input_sel        = sel_q[CCR_SEL_B_POS +: 2];
  assign cmpb_neg_input_sel        = sel_q[CCR_SEL_B_NEG +: 2];
  assign cmpa_pos_input_sel        = sel_q[CCR_SEL_A_POS +: 2];
  assign cmpa_neg_input_sel        = sel_q[CCR_SEL_A_NEG +: 2];
  assign internal_cap_select       = cap_q[CCR_CAP_INT +: 2];
  assign external_cap_pin_select   = cap_q[CCR_CAP_EXT +: 2];
  assign comparator_output_options = opt_q;
  assign cmpa_lut_out              = cif.cmpa_lut;
  assign cmpb_lut_out              = cif.cmpb_lut;
  assign cmpa_latched_flag         = cif.cmpa_flag;
  assign cmpb_latched_flag         = cif.cmpb_flag;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_live_read;
    rd && addr == CCR_ADDR_RDC
      |=> rdata[CCR_RDC_A_LIVE] == $past(live_a)
       && rdata[CCR_RDC_B_LIVE] == $past(live_b);
  endproperty
  a_live_read: assert property (p_live_read)
    else $error("live status read differs from comparator state");

  property p_live_off;
    rd && addr == CCR_ADDR_RDC
      |=> ($past(cmpb_power_enable) || !rdata[CCR_RDC_B_LIVE])
       && ($past(cmpa_power_enable) || !rdata[CCR_RDC_A_LIVE]);
  endproperty
  a_live_off: assert property (p_live_off)
    else $error("disabled comparator reads as high");

  property p_flag_read;
    rd && addr == CCR_ADDR_RDC
      |=> rdata[CCR_RDC_B_FLAG] == $past(cmpb_latched_flag)
       && rdata[CCR_RDC_A_FLAG] == $past(cmpa_latched_flag);
  endproperty
  a_flag_read: assert property (p_flag_read)
    else $error("flag read differs from latched flag");

  property p_sw_clear_a;
    wr_rdc && !wdata[CCR_RDC_A_FLAG] && !opt_q[CCR_OPT_A_CLR] && !live_a
      |=> !cmpa_latched_flag;
  endproperty
  a_sw_clear_a: assert property (p_sw_clear_a)
    else $error("cmpa flag survived a software clear");

  property p_sel_write;
    wr && addr == CCR_ADDR_SEL
      |=> {cmpb_pos_input_sel, cmpb_neg_input_sel,
           cmpa_pos_input_sel, cmpa_neg_input_sel} == $past(wdata);
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("input select fields not written");

  property p_enr_write;
    wr && addr == CCR_ADDR_ENR
      |=> {cmpb_range_limit, cmpb_power_enable,
           cmpa_range_limit, cmpa_power_enable}
          == {$past(wdata[5]), $past(wdata[4]),
              $past(wdata[1]), $past(wdata[0])};
  endproperty
  a_enr_write: assert property (p_enr_write)
    else $error("enable and range bits not written");

  property p_cap_write;
    wr && addr == CCR_ADDR_CAP
      |=> {internal_cap_select, external_cap_pin_select}
          == $past(wdata[3:0]);
  endproperty
  a_cap_write: assert property (p_cap_write)
    else $error("capacitor fields not written");

  property p_sel_reset;
    rst |=> sel_q == 8'h00;
  endproperty
  a_sel_reset: assert property (disable iff (1'b0) p_sel_reset)
    else $error("input select not zero after reset");

  property p_unused_zero;
    rd |=> ($past(addr) != CCR_ADDR_RDC || (rdata & 8'hcc) == 8'h00)
      && ($past(addr) != CCR_ADDR_ENR || (rdata & ~CCR_ENR_MASK) == 8'h00)
      && ($past(addr) != CCR_ADDR_CAP || (rdata & ~CCR_CAP_MASK) == 8'h00);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bits read nonzero");

  property p_edge_clear_b;
    cif.cmpb_clr_src && $rose(cif.cmpa_lut) && !live_b
      |=> !cmpb_latched_flag;
  endproperty
  a_edge_clear_b: assert property (p_edge_clear_b)
    else $error("cmpb flag not cleared by cmpa function edge");

  property p_sw_ignored_a;
    cif.cmpa_clr_src && cif.cmpa_sw_clr && !$rose(cif.cmpb_lut)
      && cmpa_latched_flag |=> cmpa_latched_flag;
  endproperty
  a_sw_ignored_a: assert property (p_sw_ignored_a)
    else $error("cmpa flag cleared by software in edge mode");

  property p_edge_ignored;
    (!cif.cmpa_clr_src && !cif.cmpa_sw_clr && cmpa_latched_flag
      |=> cmpa_latched_flag)
    and (!cif.cmpb_clr_src && !cif.cmpb_sw_clr && cmpb_latched_flag
      |=> cmpb_latched_flag);
  endproperty
  a_edge_ignored: assert property (p_edge_ignored)
    else $error("flag cleared by function edge in software mode");

  property p_flag_set;
    (live_a |=> cmpa_latched_flag) and (live_b |=> cmpb_latched_flag);
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("high comparator did not set its flag");

  property p_unmapped_zero;
    rd && addr != CCR_ADDR_CAP && addr != CCR_ADDR_RDC
       && addr != CCR_ADDR_SEL && addr != CCR_ADDR_ENR
       && addr != CCR_ADDR_OPT && addr != CCR_ADDR_LUT
      |=> rdata == 8'h00;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped address reads nonzero");

  property p_read_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data shown outside the read cycle");

  property p_opt_write;
    wr && addr == CCR_ADDR_OPT
      |=> comparator_output_options == $past(wdata);
  endproperty
  a_opt_write: assert property (p_opt_write)
    else $error("output options not written");

  property p_func_write;
    wr && addr == CCR_ADDR_LUT
      |=> {cif.cmpb_func_sel, cif.cmpa_func_sel} == $past(wdata);
  endproperty
  a_func_write: assert property (p_func_write)
    else $error("logic function selectors not written");

  c_flag_set: cover property (!cmpa_latched_flag ##1 cmpa_latched_flag);
  c_sw_clear: cover property (cmpb_latched_flag && cif.cmpb_sw_clr);
  c_live_high: cover property (rd && addr == CCR_ADDR_RDC && live_b);
  c_edge_clear_b: cover property (cif.cmpb_clr_src && cmpb_latched_flag
    && $rose(cif.cmpa_lut));
endmodule
